// ==== core/adcpe_core.sv ====
// Serial configuration core: static power, instruction echo, input span,
// pair setup and channel choice by scan mode.
// Assumes a host that drives 16-bit frames, MSB first, with sclk far slower
// than i_clock; all pins are sampled through two flops.
`timescale 1ns/1ps
import adcpe_pkg::*;

// What this block does
// - Power field 00 keeps everything powered
// - Field 01 shuts all, registers kept
// - Field 10 keeps reference and buffer only
// - Echo clear: no instruction on output
// - Echo set: frame n word out in n+1
// - Echo starts one full frame after enable
// - Header 10011 writes the span register
// - Span bits 10..3 map pairs; set = full
// - Span bits reset zero; bits 2..0 unused
// - Span applies only to bipolar differential pairs
// - Mode from scan control; pair setup elsewhere
// - Every pair coded like the first pair
// - Manual, repeat, ascending, top use channel select
// - Masked scan modes use the sixteen-bit mask
module adcpe_core (
    // Clock and reset
    input  wire logic                          i_clock,
    input  wire logic                          i_rst_b,
    // Serial pins from the host
    input  wire adcpe_pkg::adcpe_pins_t        i_pins,
    // Serial data pin back to the host
    output logic                               o_dout,
    output logic                               o_dout_oe,
    // Power domain enables
    output logic                               o_main_power_en,
    output logic                               o_ref_power_en,
    // Pair setup to the analog front end
    output logic [adcpe_pkg::ADCPE_PAIRS-1:0]  o_pair_bipolar_diff,
    output logic [adcpe_pkg::ADCPE_PAIRS-1:0]  o_pair_unipolar_diff,
    output logic [adcpe_pkg::ADCPE_PAIRS-1:0]  o_pair_span_full,
    // Channel choice to the sequencer
    output logic [3:0]                         o_scan_mode,
    output logic [adcpe_pkg::ADCPE_CHANS-1:0]  o_channel_enable
);

    import adcpe_pkg::*;

    // ----------------------------------------
    // Pin synchronisation
    // ----------------------------------------
    adcpe_pins_t pin_lvl;                              // Synchronised levels
    adcpe_pins_t pin_rise;                             // Rising edge pulses
    adcpe_pins_t pin_fall;                             // Falling edge pulses

    adcpe_pin_sync #(
        .W       (3),
        .RST     (adcpe_pins_t'{cs_b: 1'b1, sclk: 1'b0, din: 1'b0})  // Deselected, sclk parked low
    ) u_sync (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_async (i_pins),
        .o_level (pin_lvl),
        .o_rise  (pin_rise),
        .o_fall  (pin_fall)
    );

    // ----------------------------------------
    // State
    // ----------------------------------------
    adcpe_state_t             state_q, state_d;        // Frame tracker
    logic [4:0]               cnt_q, cnt_d;            // Bits taken this frame
    logic [ADCPE_WORD_W-1:0]  rx_q, rx_d;              // Incoming instruction
    logic [ADCPE_WORD_W-1:0]  tx_q, tx_d;              // Outgoing shift word
    logic [ADCPE_WORD_W-1:0]  echo_word_q, echo_word_d;// Word of the last frame, short or full
    logic                     echo_ok_q, echo_ok_d;    // Last word may be echoed
    logic                     echo_arm_q, echo_arm_d;  // Echo was on at frame start
    adcpe_cfg_t               cfg_q, cfg_d;            // Power and echo settings
    logic [7:0]               span_q, span_d;          // Span per pair, pair 0 on top
    logic [7:0]               unip_q, unip_d;          // Unipolar differential per pair
    logic [7:0]               bip_q, bip_d;            // Bipolar differential per pair
    logic [15:0]              mask_q, mask_d;          // Custom scan mask
    logic [3:0]               smode_q, smode_d;        // Scan mode code
    logic [3:0]               chs_q, chs_d;            // Channel select field
    logic                     dout_q, dout_d;          // Serial output flop
    logic                     oe_q, oe_d;              // Serial output enable

    // ----------------------------------------
    // Frame shifting and register decode
    // ----------------------------------------
    always_comb begin
        state_d     = state_q;
        cnt_d       = cnt_q;
        rx_d        = rx_q;
        tx_d        = tx_q;
        echo_word_d = echo_word_q;
        echo_ok_d   = echo_ok_q;
        echo_arm_d  = echo_arm_q;
        cfg_d       = cfg_q;
        span_d      = span_q;
        unip_d      = unip_q;
        bip_d       = bip_q;
        mask_d      = mask_q;
        smode_d     = smode_q;
        chs_d       = chs_q;
        dout_d      = dout_q;
        oe_d        = oe_q;
        case (state_q)
            // Waiting for the host to open a frame
            ADCPE_IDLE: begin
                if (pin_fall.cs_b) begin
                    state_d    = ADCPE_SHIFT;
                    cnt_d      = '0;
                    oe_d       = 1'b1;
                    // Echo off: nothing of the instruction goes out
                    if (cfg_q.echo && echo_ok_q) begin
                        tx_d = echo_word_q;
                    end else begin
                        tx_d = ADCPE_WORD_RST;
                    end
                    dout_d     = tx_d[ADCPE_WORD_W-1];
                    // Only frames that start with echo on feed the next one
                    echo_arm_d = cfg_q.echo;
                end
            end
            // Inside a frame
            ADCPE_SHIFT: begin
                if (pin_rise.cs_b) begin
                    state_d   = ADCPE_IDLE;
                    oe_d      = 1'b0;
                    dout_d    = 1'b0;
                    echo_word_d = rx_q;
                    // Short frames are dropped and break the echo chain
                    echo_ok_d = echo_arm_q && (cnt_q == ADCPE_CNT_FULL);
                    if (cnt_q == ADCPE_CNT_FULL) begin
                        if (!rx_q[ADCPE_MODE_BIT]) begin
                            // Scan control picks the mode
                            smode_d = rx_q[ADCPE_SMOD_HI:ADCPE_SMOD_LO];
                            chs_d   = rx_q[ADCPE_CHS_HI:ADCPE_CHS_LO];
                        end else begin
                            case (rx_q[ADCPE_HDR_HI:ADCPE_HDR_LO])
                                ADCPE_HDR_CFG: begin
                                    // Undefined power code 11 is stored as is
                                    cfg_d.spm  = rx_q[ADCPE_SPM_HI:ADCPE_SPM_LO];
                                    cfg_d.echo = rx_q[ADCPE_ECHO_BIT];
                                end
                                ADCPE_HDR_SPAN: begin
                                    // Bits 2..0 carry nothing and are dropped
                                    span_d = rx_q[ADCPE_PAIR_HI:ADCPE_PAIR_LO];
                                end
                                ADCPE_HDR_UNIP: begin
                                    unip_d = rx_q[ADCPE_PAIR_HI:ADCPE_PAIR_LO];
                                end
                                ADCPE_HDR_BIP: begin
                                    bip_d = rx_q[ADCPE_PAIR_HI:ADCPE_PAIR_LO];
                                end
                                ADCPE_HDR_MASK_HI: begin
                                    mask_d[15:8] = rx_q[ADCPE_PAIR_HI:ADCPE_PAIR_LO];
                                end
                                ADCPE_HDR_MASK_LO: begin
                                    mask_d[7:0] = rx_q[ADCPE_PAIR_HI:ADCPE_PAIR_LO];
                                end
                                default: begin
                                    // Other registers live outside this block
                                end
                            endcase
                        end
                    end
                end else begin
                    // Data taken on sclk rise, extra bits ignored
                    if (pin_rise.sclk && (cnt_q != ADCPE_CNT_FULL)) begin
                        rx_d  = {rx_q[ADCPE_WORD_W-2:0], pin_lvl.din};
                        cnt_d = cnt_q + 5'h01;
                    end
                    // Next output bit launched on sclk fall
                    if (pin_fall.sclk && (cnt_q != 5'h00)) begin
                        tx_d   = {tx_q[ADCPE_WORD_W-2:0], 1'b0};
                        dout_d = tx_q[ADCPE_WORD_W-2];
                    end
                end
            end
            default: begin
                state_d = ADCPE_IDLE;
                oe_d    = 1'b0;
                dout_d  = 1'b0;
            end
        endcase
    end

    // Shutdown never clears these: contents survive every power state
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q     <= ADCPE_IDLE;
            cnt_q       <= 5'h00;
            rx_q        <= ADCPE_WORD_RST;
            tx_q        <= ADCPE_WORD_RST;
            echo_word_q <= ADCPE_WORD_RST;
            echo_ok_q   <= 1'b0;
            echo_arm_q  <= 1'b0;
            cfg_q.spm   <= ADCPE_SPM_RST;
            cfg_q.echo  <= ADCPE_ECHO_RST;
            span_q      <= ADCPE_PAIR_RST;
            unip_q      <= ADCPE_PAIR_RST;
            bip_q       <= ADCPE_PAIR_RST;
            mask_q      <= ADCPE_MASK_RST;
            smode_q     <= ADCPE_MODE_HOLD;
            chs_q       <= ADCPE_CHS_RST;
            dout_q      <= 1'b0;
            oe_q        <= 1'b0;
        end else begin
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            rx_q        <= rx_d;
            tx_q        <= tx_d;
            echo_word_q <= echo_word_d;
            echo_ok_q   <= echo_ok_d;
            echo_arm_q  <= echo_arm_d;
            cfg_q       <= cfg_d;
            span_q      <= span_d;
            unip_q      <= unip_d;
            bip_q       <= bip_d;
            mask_q      <= mask_d;
            smode_q     <= smode_d;
            chs_q       <= chs_d;
            dout_q      <= dout_d;
            oe_q        <= oe_d;
        end
    end

    // ----------------------------------------
    // Power domain decode
    // ----------------------------------------
    logic main_pwr_d;                                  // Converter core powered
    logic ref_pwr_d;                                   // Reference and buffer powered
    logic main_pwr_q;
    logic ref_pwr_q;

    // Unused code 11 falls back to full power, the safe side
    always_comb begin
        case (cfg_q.spm)
            ADCPE_SPM_NORMAL: begin
                main_pwr_d = 1'b1;
                ref_pwr_d  = 1'b1;
            end
            ADCPE_SPM_FULL: begin
                main_pwr_d = 1'b0;
                ref_pwr_d  = 1'b0;
            end
            ADCPE_SPM_PARTIAL: begin
                main_pwr_d = 1'b0;
                ref_pwr_d  = 1'b1;
            end
            default: begin
                main_pwr_d = 1'b1;
                ref_pwr_d  = 1'b1;
            end
        endcase
    end

    // ----------------------------------------
    // Per-pair setup, one copy of the pair 0 logic each
    // ----------------------------------------
    logic [ADCPE_PAIRS-1:0] pbip_d, punip_d, pspan_d;  // Next pair outputs
    logic [ADCPE_PAIRS-1:0] pbip_q, punip_q, pspan_q;

    for (genvar p = 0; p < ADCPE_PAIRS; p++) begin : g_pair
        // Register bit 7 is pair 0, bit 0 is pair 7
        always_comb begin
            pbip_d[p]  = bip_q[ADCPE_PAIRS-1-p];
            // Bipolar wins when both are set
            punip_d[p] = unip_q[ADCPE_PAIRS-1-p] & ~bip_q[ADCPE_PAIRS-1-p];
            // Span only reaches pairs that are bipolar differential
            pspan_d[p] = span_q[ADCPE_PAIRS-1-p] & bip_q[ADCPE_PAIRS-1-p];
        end
    end

    // ----------------------------------------
    // Channel choice per channel
    // ----------------------------------------
    logic [ADCPE_CHANS-1:0] chen_d, chen_q;            // Channels to convert

    for (genvar c = 0; c < ADCPE_CHANS; c++) begin : g_chan
        always_comb begin
            case (smode_q)
                ADCPE_MODE_MANUAL, ADCPE_MODE_REPEAT: begin
                    chen_d[c] = (chs_q == 4'(c));
                end
                ADCPE_MODE_ASC_INT, ADCPE_MODE_ASC_EXT: begin
                    chen_d[c] = (4'(c) <= chs_q);
                end
                ADCPE_MODE_TOP_INT, ADCPE_MODE_TOP_EXT: begin
                    chen_d[c] = (4'(c) >= chs_q);
                end
                ADCPE_MODE_MASK_INT, ADCPE_MODE_MASK_EXT: begin
                    chen_d[c] = mask_q[c];
                end
                default: begin
                    chen_d[c] = 1'b0;
                end
            endcase
        end
    end

    // Output flops so every port comes straight from a register
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            main_pwr_q <= 1'b1;
            ref_pwr_q  <= 1'b1;
            pbip_q     <= ADCPE_PAIR_RST;
            punip_q    <= ADCPE_PAIR_RST;
            pspan_q    <= ADCPE_PAIR_RST;
            chen_q     <= ADCPE_MASK_RST;
        end else begin
            main_pwr_q <= main_pwr_d;
            ref_pwr_q  <= ref_pwr_d;
            pbip_q     <= pbip_d;
            punip_q    <= punip_d;
            pspan_q    <= pspan_d;
            chen_q     <= chen_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_dout               = dout_q;
    assign o_dout_oe            = oe_q;
    assign o_main_power_en      = main_pwr_q;
    assign o_ref_power_en       = ref_pwr_q;
    assign o_pair_bipolar_diff  = pbip_q;
    assign o_pair_unipolar_diff = punip_q;
    assign o_pair_span_full     = pspan_q;
    assign o_scan_mode          = smode_q;
    assign o_channel_enable     = chen_q;

endmodule

// ==== core/adcpe_pin_sync.sv ====
// Two-flop synchroniser with edge pulses for the serial pins.
// Assumes the pins are asynchronous to i_clock and change slowly against it.
`timescale 1ns/1ps
module adcpe_pin_sync #(
    parameter int           W   = 3,
    parameter logic [W-1:0] RST = '1                   // Idle level of each pin
) (
    // Clock and reset
    input  wire logic         i_clock,
    input  wire logic         i_rst_b,
    // Raw pins
    input  wire logic [W-1:0] i_async,
    // Synchronised views
    output logic      [W-1:0] o_level,
    output logic      [W-1:0] o_rise,
    output logic      [W-1:0] o_fall
);

    logic [W-1:0] meta_q, meta_d;                      // First stage, read only by sync
    logic [W-1:0] sync_q, sync_d;                      // Second stage
    logic [W-1:0] prev_q, prev_d;                      // Delayed copy for edges

    // ----------------------------------------
    // Next values
    // ----------------------------------------
    always_comb begin
        meta_d = i_async;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    // Stages start at each pin's idle level, so no false edge follows reset
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_q <= RST;
            sync_q <= RST;
            prev_q <= RST;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // Edges are seen only after the second stage
    assign o_level = sync_q;
    assign o_rise  = sync_q & ~prev_q;
    assign o_fall  = ~sync_q & prev_q;

endmodule

// ==== core/adcpe_pkg.sv ====
// Package for the power, echo and input-span configuration block.
// Assumes one 100 MHz core clock and 16-bit serial instruction frames.
package adcpe_pkg;

    // ----------------------------------------
    // Frame geometry
    // ----------------------------------------
    localparam int          ADCPE_WORD_W   = 16;       // Instruction width
    localparam logic [4:0]  ADCPE_CNT_FULL = 5'h10;    // Bits in a complete frame
    localparam int          ADCPE_HDR_HI   = 15;       // Register select field
    localparam int          ADCPE_HDR_LO   = 11;
    localparam int          ADCPE_MODE_BIT = 15;       // Clear selects mode control

    // ----------------------------------------
    // Register select codes in bits 15:11
    // ----------------------------------------
    localparam logic [4:0]  ADCPE_HDR_CFG     = 5'h10; // Converter configuration
    localparam logic [4:0]  ADCPE_HDR_UNIP    = 5'h11; // Unipolar pair setup
    localparam logic [4:0]  ADCPE_HDR_BIP     = 5'h12; // Bipolar pair setup
    localparam logic [4:0]  ADCPE_HDR_SPAN    = 5'h13; // Input span select
    localparam logic [4:0]  ADCPE_HDR_MASK_HI = 5'h14; // Scan mask channels 15..8
    localparam logic [4:0]  ADCPE_HDR_MASK_LO = 5'h15; // Scan mask channels 7..0

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int          ADCPE_SPM_HI   = 4;        // Static power field
    localparam int          ADCPE_SPM_LO   = 3;
    localparam int          ADCPE_ECHO_BIT = 2;        // Echo control bit
    localparam int          ADCPE_PAIR_HI  = 10;       // Per-pair bits, pair 0 on top
    localparam int          ADCPE_PAIR_LO  = 3;
    localparam int          ADCPE_SMOD_HI  = 14;       // Scan mode code
    localparam int          ADCPE_SMOD_LO  = 11;
    localparam int          ADCPE_CHS_HI   = 10;       // Channel select field
    localparam int          ADCPE_CHS_LO   = 7;
    localparam int          ADCPE_PAIRS    = 8;
    localparam int          ADCPE_CHANS    = 16;

    // ----------------------------------------
    // Static power encodings
    // ----------------------------------------
    localparam logic [1:0]  ADCPE_SPM_NORMAL  = 2'h0;
    localparam logic [1:0]  ADCPE_SPM_FULL    = 2'h1;
    localparam logic [1:0]  ADCPE_SPM_PARTIAL = 2'h2;

    // ----------------------------------------
    // Scan mode codes
    // ----------------------------------------
    localparam logic [3:0]  ADCPE_MODE_HOLD      = 4'h0;
    localparam logic [3:0]  ADCPE_MODE_MANUAL    = 4'h1;
    localparam logic [3:0]  ADCPE_MODE_REPEAT    = 4'h2;
    localparam logic [3:0]  ADCPE_MODE_ASC_INT   = 4'h3;
    localparam logic [3:0]  ADCPE_MODE_ASC_EXT   = 4'h4;  // ascending_scan_ext
    localparam logic [3:0]  ADCPE_MODE_TOP_INT   = 4'h5;
    localparam logic [3:0]  ADCPE_MODE_TOP_EXT   = 4'h6;  // top_scan_ext
    localparam logic [3:0]  ADCPE_MODE_MASK_INT  = 4'h7;  // masked_scan_int
    localparam logic [3:0]  ADCPE_MODE_MASK_EXT  = 4'h8;  // masked_scan_ext

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [1:0]  ADCPE_SPM_RST   = 2'h0;
    localparam logic        ADCPE_ECHO_RST  = 1'b0;
    localparam logic [7:0]  ADCPE_PAIR_RST  = 8'h00;
    localparam logic [15:0] ADCPE_MASK_RST  = 16'h0000;
    localparam logic [15:0] ADCPE_WORD_RST  = 16'h0000;
    localparam logic [3:0]  ADCPE_CHS_RST   = 4'h0;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic cs_b;                                    // Frame select, low active
        logic sclk;                                    // Host serial clock
        logic din;                                     // Host serial data
    } adcpe_pins_t;

    typedef struct packed {
        logic [1:0] spm;                               // Static power field
        logic       echo;                              // Echo control
    } adcpe_cfg_t;

    typedef enum logic {
        ADCPE_IDLE,
        ADCPE_SHIFT
    } adcpe_state_t;

endpackage

// ==== test/adc_power_echo_span_config_tb_top.sv ====
// Testbench for the configuration core, driven through the host model.
// Assumes 100 MHz clock, reset held 16 cycles, host frames of 16 bits.
`timescale 1ns/1ps
module adc_power_echo_span_config_tb_top;
    import adcpe_pkg::*;
    logic        i_clock  = 1'b0;  // Core clock
    logic        i_rst_b  = 1'b0;  // Reset, low active
    adcpe_pins_t pins;             // Host pins
    logic        dout, oe, main_en, ref_en;
    logic [7:0]  bip, unip, span;
    logic [3:0]  mode;
    logic [15:0] chan, got, e, b, c;
    logic [1:0]  pw [3] = '{2'h1, 2'h2, 2'h0}; // Never 11
    logic [1:0]  pe [3] = '{2'h0, 2'h1, 2'h3}; // Main and reference enables
    int          n_fail   = 0;
    int          n_checks = 0;
    int          cyc      = 0;
    always #5 i_clock = ~i_clock;
    adcpe_host host (.i_clock(i_clock), .i_dout(dout), .o_pins(pins));
    adcpe_core dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_pins(pins), .o_dout(dout),
        .o_dout_oe(oe), .o_main_power_en(main_en), .o_ref_power_en(ref_en),
        .o_pair_bipolar_diff(bip), .o_pair_unipolar_diff(unip), .o_pair_span_full(span),
        .o_scan_mode(mode), .o_channel_enable(chan));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic cmp(input logic [15:0] act, input logic [15:0] exp);
        n_checks++;
        if (act !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, act, exp);
        end
    endtask
    task automatic xfer(input logic [15:0] w);
        host.frame(w, 16, got);
    endtask
    // Pair 0 sits in the top bit of the written field
    function automatic logic [7:0] rev(input logic [7:0] f);
        for (int k = 0; k < 8; k++) rev[k] = f[7-k];
    endfunction
    task automatic final_report;
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Hang guard, well above the ~5.8k cycles the run needs
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge i_clock);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_clock);
        cmp({14'h0, main_en, ref_en}, 16'h0003);
        cmp({bip, span}, 16'h0000);
        // Pair kinds, then span with junk in the unused bits
        xfer({ADCPE_HDR_BIP, 8'hF0, 3'h0});
        xfer({ADCPE_HDR_UNIP, 8'h3C, 3'h0});
        xfer({ADCPE_HDR_SPAN, 8'hCC, 3'h7});
        cmp({bip, span}, {rev(8'hF0), rev(8'hC0)});
        cmp({8'h0, unip}, {8'h0, rev(8'h0C)});
        // Power modes; bipolar and span pair setup must survive each
        for (int k = 0; k < 3; k++) begin
            xfer({ADCPE_HDR_CFG, 6'h0, pw[k], 3'h0});
            cmp({14'h0, main_en, ref_en}, {14'h0, pe[k]});
            cmp({bip, span}, {rev(8'hF0), rev(8'hC0)});
        end
        // Every scan mode with channel select 5
        xfer({ADCPE_HDR_MASK_HI, 8'hA3, 3'h0});
        xfer({ADCPE_HDR_MASK_LO, 8'h5C, 3'h0});
        for (int m = 0; m < 9; m++) begin
            xfer({1'b0, m[3:0], 4'h5, 7'h00});
            case (m)
                1, 2: e = 16'h0020;
                3, 4: e = 16'h003F;
                5, 6: e = 16'hFFE0;
                7, 8: e = 16'hA35C;
                default: e = 16'h0000;
            endcase
            cmp({12'h0, mode}, {12'h0, m[3:0]});
            cmp(chan, e);
        end
        // Echo off, enable, then one-frame lag
        b = {ADCPE_HDR_SPAN, 8'h5A, 3'h0};
        c = {ADCPE_HDR_MASK_HI, 8'h96, 3'h0};
        xfer(16'h8004);
        cmp(got, 16'h0000);
        xfer(b);
        cmp(got, 16'h0000);
        xfer(c);
        cmp(got, b);
        xfer(16'h8004);
        cmp(got, c);
        final_report();
    end
endmodule

// ==== test/adcpe_core_sva.sv ====
// Checker for the power, echo and span configuration core.
// Assumes it sees only the core's ports; bound in at the foot of this file.
`timescale 1ns/1ps
module adcpe_core_sva (
    // Clock and reset
    input wire logic                   i_clock,
    input wire logic                   i_rst_b,
    // Watched pins and outputs
    input wire adcpe_pkg::adcpe_pins_t i_pins,
    input wire logic                   o_dout,
    input wire logic                   o_dout_oe,
    input wire logic                   o_main_power_en,
    input wire logic                   o_ref_power_en,
    input wire logic [7:0]             o_pair_bipolar_diff,
    input wire logic [7:0]             o_pair_unipolar_diff,
    input wire logic [7:0]             o_pair_span_full
);
    import adcpe_pkg::*;
    // ----------------------------------------
    // One domain, so one clocking and disable
    // ----------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    // Undriven output pin must sit low
    idle_dout_a: assert property (!o_dout_oe |-> !o_dout)
        else $error("dout high while not driven");
    // Driver opens shortly after frame start
    oe_open_a: assert property ($fell(i_pins.cs_b) |-> ##[1:6] o_dout_oe)
        else $error("dout not driven in frame");
    // Driver releases shortly after frame end
    oe_close_a: assert property ($rose(i_pins.cs_b) |-> ##[1:6] !o_dout_oe)
        else $error("dout still driven after frame");
    // Power moves only once a frame has closed
    power_hold_a: assert property ($changed({o_main_power_en, o_ref_power_en})
        |-> i_pins.cs_b && $past(i_pins.cs_b, 2)) else $error("power changed inside frame");
    // Bipolar and span pair outputs move only once a frame has closed
    span_hold_a: assert property ($changed({o_pair_bipolar_diff, o_pair_span_full})
        |-> i_pins.cs_b && $past(i_pins.cs_b, 2)) else $error("pair setup changed inside frame");
    // Full span only where the pair is bipolar
    span_bip_a: assert property ((o_pair_span_full & ~o_pair_bipolar_diff) == 8'h00)
        else $error("span applied to non bipolar pair");
    // A pair is never both kinds at once
    pair_excl_a: assert property ((o_pair_bipolar_diff & o_pair_unipolar_diff) == 8'h00)
        else $error("pair both unipolar and bipolar");
    // Reference off means full shutdown
    ref_main_a: assert property (!o_ref_power_en |-> !o_main_power_en)
        else $error("main powered without reference");
    // Main scenarios reached
    cover property ($fell(o_ref_power_en));
    cover property ($rose(o_main_power_en));
    cover property (o_pair_span_full != 8'h00);
endmodule

bind adcpe_core adcpe_core_sva chk (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_pins(i_pins),
    .o_dout(o_dout), .o_dout_oe(o_dout_oe), .o_main_power_en(o_main_power_en),
    .o_ref_power_en(o_ref_power_en), .o_pair_bipolar_diff(o_pair_bipolar_diff),
    .o_pair_unipolar_diff(o_pair_unipolar_diff), .o_pair_span_full(o_pair_span_full));

// ==== test/adcpe_host.sv ====
// Serial host model: sends 16-bit frames MSB first and reads dout back.
// Assumes the caller runs on i_clock; sclk is 16 core clocks a period.
`timescale 1ns/1ps
module adcpe_host (
    // Clock
    input  wire logic              i_clock,
    // Data back from the core
    input  wire logic              i_dout,
    // Pins to the core
    output adcpe_pkg::adcpe_pins_t o_pins
);
    import adcpe_pkg::*;
    // Deselected, sclk parked low
    initial o_pins = 3'b100;
    // ----------------------------------------
    // One frame; rd holds what dout shifted out
    // ----------------------------------------
    task automatic frame(input logic [15:0] w, input int nb, output logic [15:0] rd);
        rd = 16'h0000;
        @(posedge i_clock);
        o_pins.cs_b <= 1'b0;
        for (int i = 0; i < nb; i++) begin
            o_pins.din  <= w[15-i];
            repeat (8) @(posedge i_clock);
            o_pins.sclk <= 1'b1;
            rd[15-i] = i_dout; // Stable: dout only moves after a fall
            repeat (8) @(posedge i_clock);
            o_pins.sclk <= 1'b0;
        end
        repeat (8) @(posedge i_clock);
        o_pins.cs_b <= 1'b1;
        o_pins.din  <= ~o_pins.din; // Released line shows no stale bit
        repeat (12) @(posedge i_clock);
    endtask
endmodule
